/* src/rxe_consts.svh */
`ifndef RXE_CONSTS_SVH
`define RXE_CONSTS_SVH
// Register indices; byte address is four times the index
`define RXE_IDX_EMD        6'h05
`define RXE_IDX_SST        6'h06
`define RXE_IDX_RXC1       6'h0B
`define RXE_IDX_CTRL       6'h10
`define RXE_IDX_STS        6'h11
`define RXE_EMD_EN_BIT     7
`define RXE_EMD_TOL_BIT    6
`define RXE_EMD_WMASK      8'hCF
`define RXE_EMD_RST        8'h00
`define RXE_SST_WMASK      8'h1F
`define RXE_SST_RST        8'h00
`define RXE_RXC1_PICK_BIT  7
`define RXE_RXC1_RST       8'h00
`define RXE_CTRL_PAR_SKIP  0
`define RXE_CTRL_CRC_SKIP  1
`define RXE_CTRL_NRT_PAY   2
`define RXE_CTRL_AM_EN     3
`define RXE_CTRL_PM_EN     4
`define RXE_CTRL_MANUAL    5
`define RXE_CTRL_WMASK     8'h3F
`define RXE_CTRL_RST       8'h08
// Status fields, bits 0 to 4 sticky, write one to clear; RXE_STS_USE_PM reads the live channel choice
`define RXE_STS_SOFT       0
`define RXE_STS_RESTART    1
`define RXE_STS_EMD        2
`define RXE_STS_CRC        3
`define RXE_STS_START      4
`define RXE_STS_USE_PM     5
`define RXE_HEAD_BITS      3'd4
// Quarter etu at 106 kb/s, in ps, and clock period in ps
`define RXE_QETU_PS        2359950
`define RXE_CLK_PS         50000
`define RXE_QETU_CYC       ((`RXE_QETU_PS + `RXE_CLK_PS - 1) / `RXE_CLK_PS)
`define RXE_SST_MAX        5'h1F
`define RXE_RESP_OK        2'h0
`define RXE_RESP_SLVERR    2'h2
`endif

/* src/rxe_pkg.sv */
`default_nettype none
package rxe_pkg;
    typedef enum logic [1:0] {RXE_SCR_IDLE, RXE_SCR_HEAD, RXE_SCR_BODY} rxe_scr_state_t;
    typedef enum logic       {RXE_SST_IDLE, RXE_SST_RUN} rxe_sst_state_t;
    typedef enum logic [2:0] {RXE_SEL_NONE, RXE_SEL_EMD, RXE_SEL_SST, RXE_SEL_RXC1,
                              RXE_SEL_CTRL, RXE_SEL_STS} rxe_sel_t;
    typedef struct packed {
        rxe_scr_state_t st;
        logic [2:0]     bit_cnt;
        logic           head_err;
        logic [3:0]     byte_cnt;
        logic           start;
        logic           emd_drop;
        logic           rx_err;
        logic           crc_err;
        logic           frame_ok;
    } rxe_scr_t;
    typedef struct packed {
        rxe_sst_state_t st;
        logic [5:0]     tick;
        logic [4:0]     qcnt;
        logic           soft_err;
        logic           restart;
    } rxe_sst_t;
    typedef struct packed {
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic       aw_got;
        logic       w_got;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic       wlane0;
        logic [7:0] emd;
        logic [7:0] sst;
        logic [7:0] rxc1;
        logic [7:0] ctrl;
        logic [4:0] sts;
        logic       rx_start;
        logic       soft_err;
        logic       restart;
        logic       emd_drop;
        logic       rx_err;
        logic       crc_err;
        logic       frame_ok;
        logic       use_pm;
    } rxe_top_t;
endpackage
`default_nettype wire

/* src/rxe_rx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rxe_rx_if;
    logic       isoa106;
    logic       isob106;
    logic       tol;
    logic       emd_en;
    logic       crc_skip;
    logic [3:0] thld;
    logic [4:0] sst;
    logic       start;
    logic       emd_drop;
    logic       rx_err;
    logic       crc_err;
    logic       frame_ok;
    logic       soft_err;
    logic       restart;
    modport top (output isoa106, isob106, tol, emd_en, crc_skip, thld, sst,
                 input start, emd_drop, rx_err, crc_err, frame_ok, soft_err, restart);
    modport scr (input isoa106, tol, emd_en, crc_skip, thld,
                 output start, emd_drop, rx_err, crc_err, frame_ok);
    modport tmr (input isob106, emd_en, sst, output soft_err, restart);
endinterface
`default_nettype wire

/* src/rxe_frame_screen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rxe_consts.svh"
module rxe_frame_screen (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic frame_sof,
    input  wire logic bit_valid,
    input  wire logic bit_err,
    input  wire logic byte_done,
    input  wire logic frame_eof,
    input  wire logic frame_err,
    input  wire logic crc_bad,
    rxe_rx_if.scr     rif
);
    rxe_pkg::rxe_scr_t r;
    rxe_pkg::rxe_scr_t n;
    logic              last_head;
    logic              head_bad;
    logic              short_frm;

    assign last_head = bit_valid && (r.bit_cnt == `RXE_HEAD_BITS - 3'd1);
    assign head_bad  = r.head_err || bit_err;
    assign short_frm = r.byte_cnt < rif.thld;

    always_comb begin
        n = r;
        n.start    = 1'b0;
        n.emd_drop = 1'b0;
        n.rx_err   = 1'b0;
        n.crc_err  = 1'b0;
        n.frame_ok = 1'b0;
        case (r.st)
            rxe_pkg::RXE_SCR_IDLE: begin
            end
            rxe_pkg::RXE_SCR_HEAD: begin
                if (bit_valid) begin
                    n.bit_cnt  = r.bit_cnt + 3'd1;
                    n.head_err = head_bad;
                    if (last_head) begin
                        n.st = rxe_pkg::RXE_SCR_BODY;
                        n.start = !head_bad || (rif.tol && rif.isoa106);
                    end
                end
            end
            rxe_pkg::RXE_SCR_BODY: begin
                if (byte_done && r.byte_cnt != 4'hF) begin
                    n.byte_cnt = r.byte_cnt + 4'd1;
                end
            end
            default: n.st = rxe_pkg::RXE_SCR_IDLE;
        endcase
        if (frame_eof && r.st != rxe_pkg::RXE_SCR_IDLE) begin
            n.st = rxe_pkg::RXE_SCR_IDLE;
            if (frame_err && rif.emd_en && short_frm) begin
                n.emd_drop = 1'b1;
            end else if (frame_err) begin
                n.rx_err = 1'b1;
            end else if (crc_bad && !rif.crc_skip) begin
                n.crc_err = 1'b1;
            end else begin
                n.frame_ok = 1'b1;
            end
        end
        if (frame_sof) begin
            n.st       = rxe_pkg::RXE_SCR_HEAD;
            n.bit_cnt  = 3'd0;
            n.head_err = 1'b0;
            n.byte_cnt = 4'd0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rif.start    = r.start;
    assign rif.emd_drop = r.emd_drop;
    assign rif.rx_err   = r.rx_err;
    assign rif.crc_err  = r.crc_err;
    assign rif.frame_ok = r.frame_ok;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_head_end;
        r.st == rxe_pkg::RXE_SCR_HEAD && last_head && !frame_sof && !frame_eof;
    endsequence
    a_start_clean: assert property (s_head_end and !head_bad |=> r.start)
        else $error("clean head did not start reception");
    a_start_block: assert property (s_head_end and head_bad && !(rif.tol && rif.isoa106) |=> !r.start)
        else $error("erroneous head started reception");
    a_start_tol: assert property (s_head_end and rif.tol && rif.isoa106 |=> r.start)
        else $error("tolerant head did not start reception");
    a_emd_short: assert property (frame_eof && !frame_sof && r.st != rxe_pkg::RXE_SCR_IDLE && frame_err
        && rif.emd_en && short_frm |=> r.emd_drop && !r.rx_err)
        else $error("short erroneous frame not suppressed");
    a_crc_skip: assert property (frame_eof && rif.crc_skip |=> !r.crc_err)
        else $error("crc error reported while crc skipped");
endmodule
`default_nettype wire

/* src/rxe_sst_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rxe_consts.svh"
module rxe_sst_check #(
    parameter int QETU_CYC = `RXE_QETU_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic mask_receive_timer_end,
    input  wire logic subc_detect,
    rxe_rx_if.tmr     rif
);
    rxe_pkg::rxe_sst_t r;
    rxe_pkg::rxe_sst_t n;
    logic              q_wrap;
    logic              early;

    assign q_wrap = r.tick == 6'(QETU_CYC - 1);
    assign early  = r.qcnt < rif.sst;

    always_comb begin
        n = r;
        n.soft_err = 1'b0;
        n.restart  = 1'b0;
        case (r.st)
            rxe_pkg::RXE_SST_IDLE: begin
            end
            rxe_pkg::RXE_SST_RUN: begin
                n.tick = q_wrap ? 6'd0 : r.tick + 6'd1;
                if (q_wrap && r.qcnt != `RXE_SST_MAX) begin
                    n.qcnt = r.qcnt + 5'd1;
                end
                if (subc_detect) begin
                    n.st = rxe_pkg::RXE_SST_IDLE;
                    if (early) begin
                        n.restart  = rif.emd_en;
                        n.soft_err = !rif.emd_en;
                    end
                end else if (!early) begin
                    n.st = rxe_pkg::RXE_SST_IDLE;
                end
            end
            default: n.st = rxe_pkg::RXE_SST_IDLE;
        endcase
        if (mask_receive_timer_end && rif.isob106) begin
            n.st   = rxe_pkg::RXE_SST_RUN;
            n.tick = 6'd0;
            n.qcnt = 5'd0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rif.soft_err = r.soft_err;
    assign rif.restart  = r.restart;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_early_det;
        r.st == rxe_pkg::RXE_SST_RUN && subc_detect && early && !mask_receive_timer_end;
    endsequence
    a_sst_soft: assert property (s_early_det and !rif.emd_en |=> r.soft_err && !r.restart)
        else $error("early subcarrier gave no soft error");
    a_sst_restart: assert property (s_early_det and rif.emd_en |=> r.restart && !r.soft_err)
        else $error("early subcarrier with suppression gave no restart");
    a_sst_step: assert property (r.st == rxe_pkg::RXE_SST_RUN && q_wrap && r.qcnt != `RXE_SST_MAX
        && !mask_receive_timer_end |=> r.qcnt == $past(r.qcnt) + 5'd1)
        else $error("quarter etu step missed");
    a_sst_quiet: assert property (r.st == rxe_pkg::RXE_SST_IDLE |=> !r.soft_err && !r.restart)
        else $error("subcarrier event without armed timer");
endmodule
`default_nettype wire

/* src/rxe_top.sv */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rxe_consts.svh"
// Functional notes
// - Clean first four bits signal receive start
// - Tolerance bit: start despite head error, ISO-A
// - Short erroneous frame below threshold is suppressed
// - Start time five bits, quarter etu steps
// - Early subcarrier at ISO-B raises soft error
// - With suppression, early subcarrier raises restart instead
// - One channel enabled: pick bit selects it
// - Both enabled, manual: pick bit selects framing
// - CRC skip clear checks CRC, set skips
module rxe_top #(
    parameter int ADDR_W   = 8,
    parameter int QETU_CYC = `RXE_QETU_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              mode_isoa106,
    input  wire logic              mode_isob106,
    input  wire logic              frame_sof,
    input  wire logic              bit_valid,
    input  wire logic              bit_err,
    input  wire logic              byte_done,
    input  wire logic              frame_eof,
    input  wire logic              frame_err,
    input  wire logic              crc_bad,
    input  wire logic              mask_receive_timer_end,
    input  wire logic              subc_detect,
    input  wire logic              auto_pick_pm,
    output var  logic              rx_start,
    output var  logic              emd_drop,
    output var  logic              rx_err,
    output var  logic              crc_err,
    output var  logic              frame_ok,
    output var  logic              soft_err_evt,
    output var  logic              restart_evt,
    output var  logic              am_chan_en,
    output var  logic              pm_chan_en,
    output var  logic              rx_use_pm,
    output var  logic              parity_skip,
    output var  logic              nrt_pay_mode
);
    rxe_pkg::rxe_top_t r;
    rxe_pkg::rxe_top_t n;
    rxe_rx_if          rif ();
    rxe_pkg::rxe_sel_t wsel;
    rxe_pkg::rxe_sel_t rsel;
    logic [4:0]        sts_set;
    logic [4:0]        sts_clr;
    logic              am_on;
    logic              pm_on;
    logic              pick;

    function automatic rxe_pkg::rxe_sel_t rxe_decode(input logic [ADDR_W-1:0] a);
        rxe_pkg::rxe_sel_t s;
        s = rxe_pkg::RXE_SEL_NONE;
        if (a[1:0] != 2'h0) return s;
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`RXE_IDX_EMD)) s = rxe_pkg::RXE_SEL_EMD;
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`RXE_IDX_SST)) s = rxe_pkg::RXE_SEL_SST;
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`RXE_IDX_RXC1)) s = rxe_pkg::RXE_SEL_RXC1;
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`RXE_IDX_CTRL)) s = rxe_pkg::RXE_SEL_CTRL;
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`RXE_IDX_STS)) s = rxe_pkg::RXE_SEL_STS;
        return s;
    endfunction

    assign rif.isoa106  = mode_isoa106;
    assign rif.isob106  = mode_isob106;
    assign rif.tol      = r.emd[`RXE_EMD_TOL_BIT];
    assign rif.emd_en   = r.emd[`RXE_EMD_EN_BIT];
    assign rif.crc_skip = r.ctrl[`RXE_CTRL_CRC_SKIP];
    assign rif.thld     = r.emd[3:0];
    assign rif.sst      = r.sst[4:0];

    rxe_frame_screen u_scr (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .frame_sof (frame_sof),
        .bit_valid (bit_valid),
        .bit_err   (bit_err),
        .byte_done (byte_done),
        .frame_eof (frame_eof),
        .frame_err (frame_err),
        .crc_bad   (crc_bad),
        .rif       (rif.scr)
    );

    rxe_sst_check #(.QETU_CYC(QETU_CYC)) u_sst (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .mask_receive_timer_end (mask_receive_timer_end),
        .subc_detect            (subc_detect),
        .rif                    (rif.tmr)
    );

    assign wsel    = rxe_decode(r.waddr[ADDR_W-1:0]);
    assign rsel    = rxe_decode(s_axi_araddr);
    assign am_on   = r.ctrl[`RXE_CTRL_AM_EN];
    assign pm_on   = r.ctrl[`RXE_CTRL_PM_EN];
    assign pick    = r.rxc1[`RXE_RXC1_PICK_BIT];
    assign sts_set = {rif.start, rif.crc_err, rif.emd_drop, rif.restart, rif.soft_err};
    assign sts_clr = (r.aw_got && r.w_got && !r.bvalid && wsel == rxe_pkg::RXE_SEL_STS && r.wlane0)
                     ? r.wdata[4:0] : 5'h00;

    always_comb begin
        n = r;
        n.rx_start = rif.start;
        n.emd_drop = rif.emd_drop;
        n.rx_err   = rif.rx_err;
        n.crc_err  = rif.crc_err;
        n.frame_ok = rif.frame_ok;
        n.soft_err = rif.soft_err;
        n.restart  = rif.restart;
        if (am_on ^ pm_on) begin
            n.use_pm = pick;
        end else if (am_on && pm_on) begin
            n.use_pm = r.ctrl[`RXE_CTRL_MANUAL] ? pick : auto_pick_pm;
        end else begin
            n.use_pm = 1'b0;
        end
        // Sticky status, set wins over clear
        n.sts = (r.sts & ~sts_clr) | sts_set;
        if (s_axi_awvalid && r.awready) begin
            n.aw_got = 1'b1;
            n.waddr  = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_got  = 1'b1;
            n.wdata  = s_axi_wdata[7:0];
            n.wlane0 = s_axi_wstrb[0];
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = (wsel == rxe_pkg::RXE_SEL_NONE) ? `RXE_RESP_SLVERR : `RXE_RESP_OK;
            if (r.wlane0) begin
                case (wsel)
                    rxe_pkg::RXE_SEL_EMD:  n.emd  = r.wdata & `RXE_EMD_WMASK;
                    rxe_pkg::RXE_SEL_SST:  n.sst  = r.wdata & `RXE_SST_WMASK;
                    rxe_pkg::RXE_SEL_RXC1: n.rxc1 = r.wdata;
                    rxe_pkg::RXE_SEL_CTRL: n.ctrl = r.wdata & `RXE_CTRL_WMASK;
                    default: begin
                    end
                endcase
            end
        end else if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = (rsel == rxe_pkg::RXE_SEL_NONE) ? `RXE_RESP_SLVERR : `RXE_RESP_OK;
            case (rsel)
                rxe_pkg::RXE_SEL_EMD:  n.rdata = {24'h000000, r.emd};
                rxe_pkg::RXE_SEL_SST:  n.rdata = {24'h000000, r.sst};
                rxe_pkg::RXE_SEL_RXC1: n.rdata = {24'h000000, r.rxc1};
                rxe_pkg::RXE_SEL_CTRL: n.rdata = {24'h000000, r.ctrl};
                rxe_pkg::RXE_SEL_STS:  n.rdata = {26'h0000000, r.use_pm, r.sts};
                default:               n.rdata = 32'h00000000;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r      <= '0;
            r.emd  <= `RXE_EMD_RST;
            r.sst  <= `RXE_SST_RST;
            r.rxc1 <= `RXE_RXC1_RST;
            r.ctrl <= `RXE_CTRL_RST;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rdata   = r.rdata;
    assign rx_start      = r.rx_start;
    assign emd_drop      = r.emd_drop;
    assign rx_err        = r.rx_err;
    assign crc_err       = r.crc_err;
    assign frame_ok      = r.frame_ok;
    assign soft_err_evt  = r.soft_err;
    assign restart_evt   = r.restart;
    assign am_chan_en    = r.ctrl[`RXE_CTRL_AM_EN];
    assign pm_chan_en    = r.ctrl[`RXE_CTRL_PM_EN];
    assign rx_use_pm     = r.use_pm;
    assign parity_skip   = r.ctrl[`RXE_CTRL_PAR_SKIP];
    assign nrt_pay_mode  = r.ctrl[`RXE_CTRL_NRT_PAY];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_chan_single: assert property ((am_on ^ pm_on) |=> r.use_pm == $past(pick))
        else $error("single channel not chosen by pick bit");
    a_chan_manual: assert property (am_on && pm_on && r.ctrl[`RXE_CTRL_MANUAL] |=> r.use_pm == $past(pick))
        else $error("manual framing channel not chosen by pick bit");
    a_rsvd_zero: assert property (r.sst[7:5] == 3'h0 && r.emd[5:4] == 2'h0 && r.ctrl[7:6] == 2'h0)
        else $error("reserved bits not zero");
    a_sts_setwins: assert property (rif.soft_err |=> r.sts[`RXE_STS_SOFT])
        else $error("soft error event lost in status");
    a_rd_answer: assert property (s_axi_arvalid && r.arready |=> r.rvalid)
        else $error("read not answered in one cycle");
endmodule
`default_nettype wire

/* test/rxe_card.sv */
`timescale 1ns/1ps
`default_nettype none
module rxe_card (
    input  wire logic aclk,
    output var  logic mask_receive_timer_end,
    output var  logic subc_detect,
    output var  logic frame_sof,
    output var  logic bit_valid,
    output var  logic bit_err,
    output var  logic byte_done,
    output var  logic frame_eof,
    output var  logic frame_err,
    output var  logic crc_bad
);
    logic [8:0] v_r = 9'h000;
    assign {mask_receive_timer_end, subc_detect, frame_sof, bit_valid, bit_err, byte_done, frame_eof, frame_err,
            crc_bad} = v_r;
    task automatic ev(input logic [8:0] v);
        @(posedge aclk);
        v_r <= v;
    endtask
    task automatic send(input logic [3:0] em, input int nb, input logic fe, input logic cb);
        ev(9'h040);
        for (int i = 0; i < 4; i++) ev({4'h1, em[i], 4'h0});
        for (int i = 0; i < nb; i++) ev(9'h008);
        ev({7'h01, fe, cb});
        ev(9'h000);
    endtask
    task automatic subc(input int gap);
        ev(9'h100);
        ev(9'h000);
        repeat (gap) @(posedge aclk);
        ev(9'h080);
        ev(9'h000);
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rxe_consts.svh"
module tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        mode_isoa106, mode_isob106, auto_pick_pm;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] d;
    logic [1:0]  r;
    logic [6:0]  s;
    wire logic [31:0] s_axi_rdata;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic        am_chan_en, pm_chan_en, rx_use_pm, rx_start, emd_drop, rx_err, crc_err, frame_ok;
    wire logic        soft_err_evt, restart_evt, mask_receive_timer_end, subc_detect, frame_sof, bit_valid;
    wire logic        bit_err, byte_done, frame_eof, frame_err, crc_bad, parity_skip, nrt_pay_mode;
    int               num_errors = 0;
    int               compares = 0;
    rxe_card card (.aclk, .mask_receive_timer_end, .subc_detect, .frame_sof, .bit_valid, .bit_err, .byte_done,
                   .frame_eof, .frame_err, .crc_bad);
    rxe_top #(.QETU_CYC(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_isoa106,
        .mode_isob106, .frame_sof, .bit_valid, .bit_err, .byte_done, .frame_eof, .frame_err, .crc_bad,
        .mask_receive_timer_end, .subc_detect, .auto_pick_pm, .rx_start, .emd_drop, .rx_err, .crc_err, .frame_ok,
        .soft_err_evt, .restart_evt, .am_chan_en, .pm_chan_en, .rx_use_pm, .parity_skip, .nrt_pay_mode);
    always #25 aclk = ~aclk;
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic ha, hw, hb;
        hb = 1'h0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (int n = 0; !hb; n++) begin
            if (n == 60) hang();
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
        end
    endtask
    task automatic rd(input logic [5:0] idx);
        logic ha, hr;
        hr = 1'h0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        for (int n = 0; !hr; n++) begin
            if (n == 60) hang();
            @(negedge aclk);
            ha = s_axi_arvalid & s_axi_arready;
            hr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'h0;
        end
    endtask
    task automatic watch();
        s = 7'h00;
        repeat (26) begin
            @(negedge aclk);
            s = s | {rx_start, emd_drop, rx_err, crc_err, frame_ok, soft_err_evt, restart_evt};
        end
        @(posedge aclk);
    endtask
    task automatic frm(input logic [3:0] em, input int nb, input logic fe, input logic cb);
        fork
            card.send(em, nb, fe, cb);
            watch();
        join
    endtask
    task automatic sc(input int gap);
        fork
            card.subc(gap);
            watch();
        join
    endtask
    task automatic t_regs();
        logic [5:0] ai [4] = '{`RXE_IDX_EMD, `RXE_IDX_SST, `RXE_IDX_RXC1, `RXE_IDX_CTRL};
        logic [7:0] rv [4] = '{`RXE_EMD_RST, `RXE_SST_RST, `RXE_RXC1_RST, `RXE_CTRL_RST};
        logic [7:0] mv [4] = '{`RXE_EMD_WMASK, `RXE_SST_WMASK, 8'hFF, `RXE_CTRL_WMASK};
        chk(32'(am_chan_en), 32'h1);
        for (int i = 0; i < 4; i++) begin
            rd(ai[i]);
            chk(d, 32'(rv[i]));
            wr(ai[i], 8'hFF);
            chk(32'(r), 32'(`RXE_RESP_OK));
            rd(ai[i]);
            chk(d, 32'(mv[i]));
            wr(ai[i], rv[i]);
        end
        rd(6'h0F);
        chk(32'(r), 32'(`RXE_RESP_SLVERR));
        wr(6'h0F, 8'h55);
        chk(32'(r), 32'(`RXE_RESP_SLVERR));
        $display("t_regs done");
    endtask
    task automatic t_start();
        logic [3:0] em [5] = '{4'h0, 4'h2, 4'h8, 4'h2, 4'h8};
        logic [7:0] emd [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40};
        for (int i = 0; i < 5; i++) begin
            wr(`RXE_IDX_EMD, emd[i]);
            frm(em[i], 1, 1'h0, 1'h0);
            chk(32'(s[6]), 32'(i == 0 || i > 2));
        end
        mode_isoa106 <= 1'h0;
        frm(4'h2, 1, 1'h0, 1'h0);
        chk(32'(s[6]), 32'h0);
        $display("t_start done");
    endtask
    task automatic t_frames();
        wr(`RXE_IDX_CTRL, 8'h0C);
        chk(32'({parity_skip, nrt_pay_mode, pm_chan_en, am_chan_en}), 32'h5);
        wr(`RXE_IDX_EMD, 8'hC4);
        frm(4'h0, 3, 1'h1, 1'h0);
        chk(32'(s[5:2]), 32'h8);
        frm(4'h0, 4, 1'h1, 1'h0);
        chk(32'(s[5:2]), 32'h4);
        wr(`RXE_IDX_EMD, 8'h04);
        frm(4'h0, 2, 1'h1, 1'h0);
        chk(32'(s[5:2]), 32'h4);
        frm(4'h0, 2, 1'h0, 1'h1);
        chk(32'(s[5:2]), 32'h2);
        wr(`RXE_IDX_CTRL, 8'h0E);
        frm(4'h0, 2, 1'h0, 1'h1);
        chk(32'(s[5:2]), 32'h1);
        wr(`RXE_IDX_CTRL, 8'h0C);
        $display("t_frames done");
    endtask
    task automatic t_sst();
        mode_isob106 <= 1'h1;
        wr(`RXE_IDX_SST, 8'h04);
        sc(1);
        chk(32'(s[1:0]), 32'h2);
        rd(`RXE_IDX_STS);
        chk(d, 32'h1D);
        wr(`RXE_IDX_STS, 8'h1F);
        rd(`RXE_IDX_STS);
        chk(d, 32'h0);
        sc(12);
        chk(32'(s[1:0]), 32'h0);
        wr(`RXE_IDX_EMD, 8'h84);
        sc(1);
        chk(32'(s[1:0]), 32'h1);
        $display("t_sst done");
    endtask
    task automatic t_chan();
        logic [7:0] c [6] = '{8'h0C, 8'h0C, 8'h3C, 8'h3C, 8'h1C, 8'h1C};
        logic [5:0] p = 6'b110101;
        logic [5:0] a = 6'b011000;
        logic [5:0] e = 6'b010101;
        for (int i = 0; i < 6; i++) begin
            wr(`RXE_IDX_CTRL, c[i]);
            wr(`RXE_IDX_RXC1, {p[i], 7'h00});
            auto_pick_pm <= a[i];
            repeat (3) @(posedge aclk);
            chk(32'(rx_use_pm), 32'(e[i]));
        end
        $display("t_chan done");
    endtask
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h05;
        {mode_isoa106, mode_isob106, auto_pick_pm, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 51'h4_0000_0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_start();
        t_frames();
        t_sst();
        t_chan();
        tally_and_finish();
    end
endmodule
`default_nettype wire
